// ==== psv_pkg.sv ====
// package: constants, states and carriers of the serial voltage programmer
// Operation
// - while idle the interface waits for a start condition and a 7-bit address.
// - the address is compared bit by bit and a mismatch drops the transfer.
// - the upper six address bits are fixed and bit one comes from the strap.
// - a grounded strap expects address bit one low, a strap at supply high.
// - the last address bit is the direction bit, zero write and one read.
// - only single send-byte writes are served and nothing is read back.
// - a matching address with direction bit zero is acknowledged by pulling data low in clock nine.
// - the core code maps to 0.7 V up to 1.475 V in 25 mV steps.
// - the card code maps to off, 1.8 V, 2.5 V or 3.0 V.
// - the battery output follows the io supply while enabled and good.
// - data bit five picks the core target when low and the card when high.
// - after power-up the core code means 1.3 V and the card code 0 V.
// - after a stop or a mismatch the bus clock is ignored until a start.
package psv_pkg;

    // ---------------------------------------------------------------
    // serial address and data layout
    // ---------------------------------------------------------------
    localparam logic [5:0] ADDR_HI = 6'h0A;
    localparam int TGT_BIT = 5;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [2:0] ADDR_TOP = 3'h6;

    // ---------------------------------------------------------------
    // voltage codes and levels in millivolts
    // ---------------------------------------------------------------
    localparam logic [4:0] CORE_RST = 5'h18;
    localparam logic [1:0] CARD_RST = 2'h0;
    localparam logic [10:0] CORE_BASE_MV = 11'h2BC;
    localparam logic [10:0] CORE_STEP_MV = 11'h019;
    localparam logic [11:0] CARD_OFF_MV = 12'h000;
    localparam logic [11:0] CARD_LO_MV = 12'h708;
    localparam logic [11:0] CARD_MID_MV = 12'h9C4;
    localparam logic [11:0] CARD_HI_MV = 12'hBB8;

    // ---------------------------------------------------------------
    // register map
    // ---------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CORE = 8'h04;
    localparam logic [7:0] OFS_CARD = 8'h08;
    localparam logic [7:0] OFS_STAT = 8'h0C;
    localparam logic CTRL_RST = 1'b1;
    localparam logic [2:0] SIZE_WORD = 3'h2;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_ACK_A = 3'b011,
        ST_DATA = 3'b010,
        ST_ACK_D = 3'b110,
        ST_IGNORE = 3'b100
    } psv_state_t;

    typedef struct packed {
        logic core_we;
        logic card_we;
        logic [7:0] wdata;
    } psv_wr_t;

    typedef struct packed {
        psv_state_t state;
        logic strap;
        logic active;
        logic batt_io;
        logic [4:0] core;
        logic [1:0] card;
    } psv_stat_t;

endpackage

// ==== psv_sync.sv ====
// two-flop synchroniser for a group of pin levels
`timescale 1ns/1ns
`default_nettype none
module psv_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= INIT;
            q <= INIT;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule
`default_nettype wire

// ==== psv_ahb.sv ====
// ahb-lite slave holding control and giving access to the voltage codes
`timescale 1ns/1ns
`default_nettype none
module psv_ahb import psv_pkg::*; (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire psv_stat_t stat,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output psv_wr_t wr,
    output logic serial_en
);
    logic acc, rd_req, dp_wr, rd_pend;
    logic [7:0] dp_addr;
    logic [31:0] rd_val;

    // unmapped upper address bits or sub-word sizes are simply not served
    assign acc = hready & hsel & htrans[1] & (hsize == SIZE_WORD)
        & (haddr[31:8] == 24'h000000);
    assign rd_req = acc & ~hwrite;

    // ---------------------------------------------------------------
    // address phase capture; reads take one wait state
    // ---------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr <= 1'b0;
            dp_addr <= 8'h00;
            rd_pend <= 1'b0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            if (hready) begin
                dp_wr <= acc & hwrite;
                dp_addr <= haddr[7:0];
            end
            rd_pend <= rd_req;
            hreadyout <= ~rd_req;
            hresp <= 1'b0;
        end
    end

    // the wait state lets a preceding write land before the read samples
    always_comb begin
        case (dp_addr)
            OFS_CTRL: rd_val = {31'h0, serial_en};
            OFS_CORE: rd_val = {27'h0, stat.core};
            OFS_CARD: rd_val = {30'h0, stat.card};
            OFS_STAT: rd_val = {26'h0, stat.state, stat.strap, stat.active,
                stat.batt_io};
            default: rd_val = 32'h0;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0;
        end else if (rd_pend) begin
            hrdata <= rd_val;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            serial_en <= CTRL_RST;
        end else if (dp_wr && dp_addr == OFS_CTRL) begin
            serial_en <= hwdata[0];
        end
    end

    assign wr.core_we = dp_wr & (dp_addr == OFS_CORE);
    assign wr.card_we = dp_wr & (dp_addr == OFS_CARD);
    assign wr.wdata = hwdata[7:0];
endmodule
`default_nettype wire

// ==== psv_top.sv ====
// two-wire send-byte slave programming core and card supply codes
//
// Decided for this implementation: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module psv_top import psv_pkg::*; (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic address_select_strap,
    input wire logic io_supply_enable,
    input wire logic io_supply_good,
    output logic [4:0] core_supply_code,
    output logic [10:0] core_supply_mv,
    output logic [1:0] card_supply_code,
    output logic [11:0] card_supply_mv,
    output logic battery_domain_from_io,
    output logic iface_active
);
    // ---------------------------------------------------------------
    // declarations
    // ---------------------------------------------------------------
    logic [4:0] pin_s;
    logic scl_s, sda_s, strap_s, io_en_s, io_good_s;
    logic scl_d, sda_d;
    logic start, stop, scl_rise, scl_fall;
    psv_state_t state, next_state;
    logic [2:0] bit_cnt;
    logic full;
    logic [7:0] shift;
    logic [6:0] exp_addr;
    logic lat;
    logic serial_en;
    psv_wr_t wr;
    psv_stat_t stat;

    // ---------------------------------------------------------------
    // pin synchronisers; bus lines idle high
    // ---------------------------------------------------------------
    psv_sync #(
        .W(5),
        .INIT(5'h18)
    ) u_sync (
        .clk(hclk),
        .rst_n(hresetn),
        .d({scl_in, sda_in, address_select_strap, io_supply_enable,
            io_supply_good}),
        .q(pin_s)
    );

    assign scl_s = pin_s[4];
    assign sda_s = pin_s[3];
    assign strap_s = pin_s[2];
    assign io_en_s = pin_s[1];
    assign io_good_s = pin_s[0];

    // ---------------------------------------------------------------
    // register bus
    // ---------------------------------------------------------------
    psv_ahb u_ahb (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .stat(stat),
        .hrdata(hrdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .wr(wr),
        .serial_en(serial_en)
    );

    assign stat.state = state;
    assign stat.strap = strap_s;
    assign stat.active = iface_active;
    assign stat.batt_io = battery_domain_from_io;
    assign stat.core = core_supply_code;
    assign stat.card = card_supply_code;

    // ---------------------------------------------------------------
    // bus condition detection
    // ---------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    assign start = scl_s & scl_d & sda_d & ~sda_s;
    assign stop = scl_s & scl_d & ~sda_d & sda_s;
    assign scl_rise = scl_s & ~scl_d;
    assign scl_fall = ~scl_s & scl_d;

    // only bit one of the address follows the strap
    assign exp_addr = {ADDR_HI, strap_s};

    // ---------------------------------------------------------------
    // transfer state machine
    // ---------------------------------------------------------------
    always_comb begin
        next_state = state;
        if (!serial_en) begin
            next_state = ST_IDLE;
        end else if (start) begin
            next_state = ST_ADDR;
        end else if (stop) begin
            next_state = ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    next_state = ST_IDLE;
                end
                ST_ADDR: begin
                    if (scl_rise && bit_cnt != LAST_BIT &&
                        sda_s != exp_addr[ADDR_TOP - bit_cnt]) begin
                        next_state = ST_IGNORE;
                    end else if (scl_rise && bit_cnt == LAST_BIT &&
                        sda_s) begin
                        next_state = ST_IGNORE;
                    end else if (scl_fall && full) begin
                        next_state = ST_ACK_A;
                    end
                end
                ST_ACK_A: begin
                    if (scl_fall) begin
                        next_state = ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (scl_fall && full) begin
                        next_state = ST_ACK_D;
                    end
                end
                ST_ACK_D: begin
                    // a single byte per transfer; later bytes get no ack
                    if (scl_fall) begin
                        next_state = ST_IGNORE;
                    end
                end
                ST_IGNORE: begin
                    next_state = ST_IGNORE;
                end
                default: begin
                    next_state = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ---------------------------------------------------------------
    // bit counter and shift register
    // ---------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bit_cnt <= 3'h0;
            full <= 1'b0;
            shift <= 8'h00;
        end else if (start || (state != ST_ADDR && state != ST_DATA)) begin
            bit_cnt <= 3'h0;
            full <= 1'b0;
        end else if (scl_rise) begin
            shift <= {shift[6:0], sda_s};
            bit_cnt <= bit_cnt + 3'h1;
            full <= (bit_cnt == LAST_BIT);
        end
    end

    // ---------------------------------------------------------------
    // voltage codes; the serial byte wins over a bus write
    // ---------------------------------------------------------------
    assign lat = (state == ST_DATA) && (next_state == ST_ACK_D);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            core_supply_code <= CORE_RST;
            card_supply_code <= CARD_RST;
        end else if (lat) begin
            if (shift[TGT_BIT]) begin
                card_supply_code <= shift[1:0];
            end else begin
                core_supply_code <= shift[4:0];
            end
        end else begin
            if (wr.core_we) begin
                core_supply_code <= wr.wdata[4:0];
            end
            if (wr.card_we) begin
                card_supply_code <= wr.wdata[1:0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            core_supply_mv <= 11'h000;
        end else begin
            core_supply_mv <= CORE_BASE_MV
                + CORE_STEP_MV * {6'h00, core_supply_code};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            card_supply_mv <= CARD_OFF_MV;
        end else begin
            case (card_supply_code)
                2'h0: card_supply_mv <= CARD_OFF_MV;
                2'h1: card_supply_mv <= CARD_LO_MV;
                2'h2: card_supply_mv <= CARD_MID_MV;
                default: card_supply_mv <= CARD_HI_MV;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // battery source selector and pin outputs
    // ---------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            battery_domain_from_io <= 1'b0;
        end else begin
            battery_domain_from_io <= io_en_s & io_good_s;
        end
    end

    // data is only ever pulled low, so the driven level is a constant
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sda_out <= 1'b0;
            sda_oe_n <= 1'b1;
            iface_active <= 1'b0;
        end else begin
            sda_out <= 1'b0;
            sda_oe_n <= ~(next_state == ST_ACK_A ||
                next_state == ST_ACK_D);
            iface_active <= (next_state != ST_IDLE &&
                next_state != ST_IGNORE);
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_IDLE_WAITS: assert property (
        state == ST_IDLE && !start |=> state == ST_IDLE)
        else $error("left idle without a start");

    AST_MISMATCH_DROPS: assert property (
        state == ST_ADDR && serial_en && !start && !stop && scl_rise &&
        bit_cnt != LAST_BIT && sda_s != exp_addr[ADDR_TOP - bit_cnt]
        |=> state == ST_IGNORE ##1 !iface_active)
        else $error("address mismatch not dropped");

    AST_STRAP_BIT: assert property (
        state == ST_ADDR && serial_en && !start && !stop && scl_rise &&
        bit_cnt == 3'h6 && sda_s != strap_s |=> state == ST_IGNORE)
        else $error("address bit one ignored the strap");

    AST_READ_NO_ACK: assert property (
        state == ST_ADDR && serial_en && !start && !stop && scl_rise &&
        bit_cnt == LAST_BIT && sda_s |=> state == ST_IGNORE ##1 sda_oe_n)
        else $error("read direction acknowledged");

    AST_ACK_DRIVE: assert property (
        (state == ST_ACK_A || state == ST_ACK_D) == !sda_oe_n)
        else $error("data line drive not aligned with acknowledge");

    AST_IGNORE_HOLD: assert property (
        state == ST_IGNORE && !start && serial_en
        |=> state == ($past(stop) ? ST_IDLE : ST_IGNORE))
        else $error("left ignore without a start");

    AST_TARGET_SEL: assert property (
        lat && !shift[TGT_BIT] |=> core_supply_code == $past(shift[4:0])
        && card_supply_code == $past(card_supply_code))
        else $error("core byte not routed to core code");

    AST_CORE_MV: assert property (
        $past(hresetn) |-> core_supply_mv == 11'(CORE_BASE_MV
        + CORE_STEP_MV * {6'h00, $past(core_supply_code)}))
        else $error("core millivolts wrong");

    AST_CARD_OFF: assert property (
        card_supply_code == 2'h0 |=> card_supply_mv == CARD_OFF_MV)
        else $error("card not off for code zero");

    AST_BATT_SEL: assert property (
        !(io_en_s && io_good_s) |=> !battery_domain_from_io)
        else $error("battery output stayed on io supply");

    COV_ADDR_ACK: cover property (state == ST_ADDR ##1 state == ST_ACK_A);
    COV_CORE_WR: cover property (lat && !shift[TGT_BIT]);
    COV_CARD_WR: cover property (lat && shift[TGT_BIT]);
    COV_MISMATCH: cover property (state == ST_ADDR ##1 state == ST_IGNORE);
endmodule
`default_nettype wire

// ==== psv_i2c_master.sv ====
// two-wire bus master model that sends send-byte frames to the block
`timescale 1ns/1ns
`default_nettype none
module psv_i2c_master (
    input wire logic clk,
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    // -----------------------------------------------------------------
    // bus phases
    // -----------------------------------------------------------------
    // clock stands high between frames; six clk cycles per half period
    // keeps each phase above the four-cycle minimum of the slave
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic half();
        repeat (6) @(posedge clk);
    endtask

    // entered right after the clock was driven low
    task automatic put_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            // data moves two cycles after the fall so it never looks
            // like a start or stop to the synchronised slave
            repeat (2) @(posedge clk);
            sda_low <= ~b[i]; // msb first
            repeat (4) @(posedge clk);
            scl <= 1'b1;
            half();
            scl <= 1'b0;
        end
        repeat (2) @(posedge clk);
        sda_low <= 1'b0;
        repeat (4) @(posedge clk);
        scl <= 1'b1;
        repeat (3) @(posedge clk);
        ack = ~sda;
        repeat (3) @(posedge clk);
        scl <= 1'b0;
    endtask

    task automatic frame(input logic [7:0] addr, input logic [7:0] d0,
                         input logic [7:0] d1, input int nb,
                         output logic [2:0] acks);
        acks = 3'h0;
        @(posedge clk);
        sda_low <= 1'b1; // start before the address
        half();
        scl <= 1'b0;
        put_byte(addr, acks[0]); // address and direction come first
        if (nb > 0) begin
            put_byte(d0, acks[1]);
        end
        if (nb > 1) begin
            put_byte(d1, acks[2]);
        end
        repeat (2) @(posedge clk);
        sda_low <= 1'b1;
        half();
        scl <= 1'b1;
        half();
        sda_low <= 1'b0; // stop ends every frame
        half();
    endtask
endmodule
`default_nettype wire

// ==== tb_pmic_serial_voltage_programmer.sv ====
// testbench: register access and serial programming of the supply codes
`timescale 1ns/1ns
`default_nettype none
module tb_pmic_serial_voltage_programmer import psv_pkg::*;;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans, card_code;
    logic [2:0] hsize, acks;
    logic scl, mst_low, sda_wire, sda_out, sda_oe_n;
    logic strap, io_en, io_good, batt_io, active;
    logic [4:0] core_code;
    logic [10:0] core_mv;
    logic [11:0] card_mv;
    logic [11:0] card_tab [4] = '{12'h000, 12'h708, 12'h9C4, 12'hBB8};
    int bad_count, n_compared;

    // -----------------------------------------------------------------
    // wiring: single slave, data line pulled up
    // -----------------------------------------------------------------
    assign hready = hreadyout;
    assign sda_wire = !(mst_low || (sda_oe_n == 1'b0 && sda_out == 1'b0));

    always #4 hclk = ~hclk;

    psv_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .scl_in(scl),
        .sda_in(sda_wire), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .address_select_strap(strap), .io_supply_enable(io_en),
        .io_supply_good(io_good), .core_supply_code(core_code),
        .core_supply_mv(core_mv), .card_supply_code(card_code),
        .card_supply_mv(card_mv), .battery_domain_from_io(batt_io),
        .iface_active(active));

    psv_i2c_master i_mst (.clk(hclk), .scl(scl), .sda_low(mst_low),
        .sda(sda_wire));

    // -----------------------------------------------------------------
    // helpers
    // -----------------------------------------------------------------
    task automatic tally_and_finish();
        if (bad_count == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // ready is judged at the falling edge, where it equals the value the
    // next rising edge samples, so no race with the slave registers
    task automatic wait_ready();
        int i;
        for (i = 0; i < 50; i++) begin
            @(negedge hclk);
            if (hreadyout === 1'b1) break;
        end
        if (i == 50) begin
            bad_count++;
            tally_and_finish();
        end
    endtask

    task automatic ahb(input logic wr, input logic [31:0] a,
                       input logic [31:0] wd, output logic [31:0] rdat);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= SIZE_WORD;
        wait_ready();
        @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rdat = hrdata;
    endtask

    task automatic frame_check(input logic [7:0] a, input logic [7:0] d0,
                               input logic [7:0] d1, input int nb,
                               input logic [2:0] ea, input logic [4:0] ec,
                               input logic [1:0] ek);
        i_mst.frame(a, d0, d1, nb, acks);
        repeat (4) @(negedge hclk);
        check(32'(acks), 32'(ea));
        check(32'(core_code), 32'(ec));
        check(32'(core_mv), 32'(11'h2BC + 11'h019 * 11'(ec)));
        check(32'(card_code), 32'(ek));
        check(32'(card_mv), 32'(card_tab[ek]));
        check(32'(active), 32'h0);
    endtask

    // -----------------------------------------------------------------
    // main sequence
    // -----------------------------------------------------------------
    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = SIZE_WORD;
        hwdata = 32'h0;
        strap = 1'b0;
        io_en = 1'b0;
        io_good = 1'b0;
        bad_count = 0;
        n_compared = 0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(negedge hclk);
        check(32'(core_code), 32'h18);
        check(32'(card_code), 32'h0);
        @(negedge hclk);
        check(32'(core_mv), 32'h514);
        check(32'(card_mv), 32'h0);
        ahb(1'b0, 32'(OFS_CTRL), 32'h0, rd);
        check(rd, 32'h1);
        ahb(1'b0, 32'(OFS_CORE), 32'h0, rd);
        check(rd, 32'h18);
        ahb(1'b0, 32'h10, 32'h0, rd);
        check(rd, 32'h0);
        check(32'(hresp), 32'h0);
        ahb(1'b1, 32'(OFS_CORE), 32'h3, rd);
        ahb(1'b0, 32'(OFS_CORE), 32'h0, rd);
        check(rd, 32'h3);
        check(32'(core_mv), 32'h307);
        // a write above the mapped window must not reach the core code
        ahb(1'b1, 32'h104, 32'h1F, rd);
        ahb(1'b0, 32'(OFS_CORE), 32'h0, rd);
        check(rd, 32'h3);
        // core codes 1F, 0F, 07 and 03, strap low
        foreach (card_tab[i]) begin
            frame_check(8'h28, 8'(5'h1F >> i), 8'h0, 1, 3'h3,
                        5'h1F >> i, 2'h0);
        end
        // card codes with don't-care bits 7, 6, 4 and 2 set; core must not move
        for (int i = 0; i < 4; i++) begin
            frame_check(8'h28, 8'hF4 | 8'((i + 1) % 4), 8'h0, 1, 3'h3,
                        5'h03, 2'((i + 1) % 4));
        end
        frame_check(8'h2C, 8'h05, 8'h0, 1, 3'h0, 5'h03, 2'h0);
        frame_check(8'hA8, 8'h05, 8'h0, 1, 3'h0, 5'h03, 2'h0);
        frame_check(8'h29, 8'h05, 8'h0, 1, 3'h0, 5'h03, 2'h0);
        frame_check(8'h28, 8'h07, 8'h11, 2, 3'h3, 5'h07, 2'h0);
        @(posedge hclk);
        strap <= 1'b1;
        frame_check(8'h2A, 8'h09, 8'h0, 1, 3'h3, 5'h09, 2'h0);
        frame_check(8'h28, 8'h02, 8'h0, 1, 3'h0, 5'h09, 2'h0);
        // serial side switched off through control
        ahb(1'b1, 32'(OFS_CTRL), 32'h0, rd);
        frame_check(8'h2A, 8'h03, 8'h0, 1, 3'h0, 5'h09, 2'h0);
        ahb(1'b1, 32'(OFS_CTRL), 32'h1, rd);
        for (int i = 0; i < 4; i++) begin
            @(posedge hclk);
            io_en <= i[1];
            io_good <= i[0];
            repeat (4) @(negedge hclk);
            check(32'(batt_io), 32'(i == 3));
            ahb(1'b0, 32'(OFS_STAT), 32'h0, rd);
            check(32'(rd[0]), 32'(i == 3));
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
